// ---- include/bcr_pkg.sv ----
// Function
// - Block is bus master only; it starts transfers and drives the clock.
// - Up to eight slaves share the bus; each is chosen by address only.
// - Board product record sits at select 000b, software address A0h.
// - User configuration record sits at select 001b, software address A2h.
// - Add-on module product record sits at select 010b, address A4h.
// - Temperature sensor at select slot 011b answers at address 96h.
// - On-board memory presence record sits at select 100b, address A8h.
// - Mezzanine records: bank C at AAh (101b), bank E at ACh (110b).
// - Memory presence records are read in the standard presence layout.
// - With banks A and B fitted, one on-board record serves both.
// - Power-up configuration is loaded before any access is accepted.
`default_nettype none
package bcr_pkg;
    localparam logic [7:0] SW_ADDR_BOARD  = 8'hA0;
    localparam logic [7:0] SW_ADDR_USER   = 8'hA2;
    localparam logic [7:0] SW_ADDR_ADDON  = 8'hA4;
    localparam logic [7:0] SW_ADDR_TEMP   = 8'h96;
    localparam logic [7:0] SW_ADDR_MEM_AB = 8'hA8;
    localparam logic [7:0] SW_ADDR_MEZ_C  = 8'hAA;
    localparam logic [7:0] SW_ADDR_MEZ_E  = 8'hAC;
    localparam logic [7:0] SW_ADDR_SPARE  = 8'hAE;

    localparam logic [2:0] SEL_BOARD  = 3'h0;
    localparam logic [2:0] SEL_USER   = 3'h1;
    localparam logic [2:0] SEL_ADDON  = 3'h2;
    localparam logic [2:0] SEL_TEMP   = 3'h3;
    localparam logic [2:0] SEL_MEM_AB = 3'h4;
    localparam logic [2:0] SEL_MEZ_C  = 3'h5;
    localparam logic [2:0] SEL_MEZ_E  = 3'h6;
    localparam logic [2:0] SEL_SPARE  = 3'h7;

    // Byte offsets read at power-up
    localparam logic [7:0] BOARD_CFG_IDX    = 8'h00;
    localparam logic [7:0] SPD_DENSITY_IDX  = 8'h1F;

    localparam int CLK_PERIOD_NS = 10;
    localparam int SCL_PERIOD_NS = 2560;
    localparam int QUARTER_CYC   = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
    localparam logic [7:0] QUARTER_LAST = 8'(QUARTER_CYC - 1);

    localparam logic [1:0] PH_LAST  = 2'h3;
    localparam logic [1:0] PH_SCLHI = 2'h1;
    localparam logic [1:0] PH_MID   = 2'h2;
    localparam logic [3:0] BIT_ACK  = 4'h8;

    localparam logic [1:0] STG_ADDR_W = 2'h0;
    localparam logic [1:0] STG_WORD   = 2'h1;
    localparam logic [1:0] STG_ADDR_R = 2'h2;
    localparam logic [1:0] STG_READ   = 2'h3;

    localparam logic [2:0] BOOT_JOBS = 3'h5;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_START = 5'h02,
        ST_TX    = 5'h04,
        ST_RX    = 5'h08,
        ST_STOP  = 5'h10
    } bcr_state_t;
endpackage
`default_nettype wire

// ---- rtl/bcr_reader.sv ----
`timescale 1ns/1ps
`default_nettype none
module bcr_reader (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_sda,
    output logic            o_sda_o,
    output logic            o_sda_oe,
    output logic            o_scl_o,
    output logic            o_scl_oe,
    input  wire logic       i_req,
    input  wire logic [2:0] i_dev_sel,
    input  wire logic [7:0] i_word_addr,
    output logic            o_req_ready,
    output logic            o_done,
    output logic            o_absent,
    output logic [7:0]      o_data,
    output logic            o_boot_done,
    output logic [7:0]      o_board_cfg,
    output logic [7:0]      o_bank_a_size,
    output logic [7:0]      o_bank_b_size,
    output logic            o_mez_c_fitted,
    output logic [7:0]      o_mez_c_size,
    output logic            o_mez_e_fitted,
    output logic [7:0]      o_mez_e_size,
    output logic            o_spare_present
);
    import bcr_pkg::*;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic [7:0] sel_to_sw(input logic [2:0] sel);
        case (sel)
            SEL_BOARD:  sel_to_sw = SW_ADDR_BOARD;
            SEL_USER:   sel_to_sw = SW_ADDR_USER;
            SEL_ADDON:  sel_to_sw = SW_ADDR_ADDON;
            SEL_TEMP:   sel_to_sw = SW_ADDR_TEMP;
            SEL_MEM_AB: sel_to_sw = SW_ADDR_MEM_AB;
            SEL_MEZ_C:  sel_to_sw = SW_ADDR_MEZ_C;
            SEL_MEZ_E:  sel_to_sw = SW_ADDR_MEZ_E;
            default:    sel_to_sw = SW_ADDR_SPARE;
        endcase
    endfunction

    function automatic logic [2:0] boot_sel(input logic [2:0] job);
        case (job)
            3'h0:    boot_sel = SEL_BOARD;
            3'h1:    boot_sel = SEL_MEM_AB;
            3'h2:    boot_sel = SEL_MEZ_C;
            3'h3:    boot_sel = SEL_MEZ_E;
            default: boot_sel = SEL_SPARE;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Reset release and pin synchroniser
    // ------------------------------------------------------------
    logic       rst_s1_ff;
    logic       rst_n;
    logic       sda_s1_ff;
    logic       sda_s2_ff;
    logic       sda_s3_ff;
    logic       sda_in_ff;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_s1_ff <= 1'b0;
            rst_n     <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_n     <= rst_s1_ff;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_s1_ff <= 1'b1;
            sda_s2_ff <= 1'b1;
            sda_s3_ff <= 1'b1;
            sda_in_ff <= 1'b1;
        end else begin
            sda_s1_ff <= i_sda;
            sda_s2_ff <= sda_s1_ff;
            sda_s3_ff <= sda_s2_ff;
            if (sda_s2_ff == sda_s3_ff) begin
                sda_in_ff <= sda_s3_ff;
            end
        end
    end

    // ------------------------------------------------------------
    // Bit timing
    // ------------------------------------------------------------
    logic [7:0] qcnt_ff;
    logic [1:0] phase_ff;
    logic       tick;
    logic       bit_end;

    assign tick    = (qcnt_ff == QUARTER_LAST);
    assign bit_end = tick && (phase_ff == PH_LAST);

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            qcnt_ff  <= 8'h00;
            phase_ff <= 2'h0;
        end else if (tick) begin
            qcnt_ff  <= 8'h00;
            phase_ff <= phase_ff + 2'h1;
        end else begin
            qcnt_ff  <= qcnt_ff + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Transfer engine
    // ------------------------------------------------------------
    bcr_state_t state_ff;
    logic [1:0] stage_ff;
    logic [3:0] bit_ff;
    logic [7:0] shift_ff;
    logic [2:0] sel_ff;
    logic [7:0] word_ff;
    logic       nack_ff;
    logic       scl_low_ff;
    logic       sda_low_ff;
    logic       done_ff;
    logic       absent_ff;
    logic [7:0] data_ff;
    logic       boot_done_ff;
    logic [2:0] job_ff;
    logic       go;
    logic       user_go;
    logic [2:0] go_sel;
    logic [7:0] go_word;
    logic [7:0] cur_sw;

    assign user_go = i_req && boot_done_ff;
    assign go      = bit_end && (state_ff == ST_IDLE) && !done_ff
                     && (user_go || !boot_done_ff);
    assign go_sel  = boot_done_ff ? i_dev_sel : boot_sel(job_ff);
    assign go_word = boot_done_ff ? i_word_addr :
                     ((job_ff == 3'h0) ? BOARD_CFG_IDX : SPD_DENSITY_IDX);
    assign cur_sw  = sel_to_sw(sel_ff);

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            stage_ff <= STG_ADDR_W;
            bit_ff   <= 4'h0;
            shift_ff <= 8'h00;
            sel_ff   <= 3'h0;
            word_ff  <= 8'h00;
            nack_ff  <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (go) begin
                        state_ff <= ST_START;
                        stage_ff <= STG_ADDR_W;
                        sel_ff   <= go_sel;
                        word_ff  <= go_word;
                        nack_ff  <= 1'b0;
                    end
                end
                ST_START: begin
                    if (bit_end) begin
                        state_ff <= ST_TX;
                        bit_ff   <= 4'h0;
                        shift_ff <= {cur_sw[7:1], (stage_ff == STG_ADDR_R)};
                    end
                end
                ST_TX: begin
                    if (tick && phase_ff == PH_MID && bit_ff == BIT_ACK) begin
                        nack_ff <= sda_in_ff;
                    end
                    if (bit_end) begin
                        shift_ff <= shift_ff << 1;
                        bit_ff   <= bit_ff + 4'h1;
                        if (bit_ff == BIT_ACK) begin
                            bit_ff <= 4'h0;
                            if (nack_ff) begin
                                state_ff <= ST_STOP;
                            end else if (stage_ff == STG_ADDR_W) begin
                                stage_ff <= STG_WORD;
                                shift_ff <= word_ff;
                            end else if (stage_ff == STG_WORD) begin
                                stage_ff <= STG_ADDR_R;
                                state_ff <= ST_START;
                            end else begin
                                stage_ff <= STG_READ;
                                state_ff <= ST_RX;
                            end
                        end
                    end
                end
                ST_RX: begin
                    if (tick && phase_ff == PH_MID && bit_ff != BIT_ACK) begin
                        shift_ff <= {shift_ff[6:0], sda_in_ff};
                    end
                    if (bit_end) begin
                        bit_ff <= bit_ff + 4'h1;
                        if (bit_ff == BIT_ACK) begin
                            state_ff <= ST_STOP;
                        end
                    end
                end
                ST_STOP: begin
                    if (bit_end) begin
                        state_ff <= ST_IDLE;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Line drive, master only
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_low_ff <= 1'b0;
            sda_low_ff <= 1'b0;
        end else if (tick) begin
            case (state_ff)
                ST_START: begin
                    scl_low_ff <= (phase_ff == PH_MID) || (phase_ff == PH_LAST);
                    sda_low_ff <= (phase_ff == PH_SCLHI) ||
                                  (phase_ff == PH_MID);
                end
                ST_TX: begin
                    scl_low_ff <= (phase_ff == PH_LAST) || (phase_ff == 2'h0);
                    if (phase_ff == 2'h0) begin
                        sda_low_ff <= (bit_ff != BIT_ACK) && !shift_ff[7];
                    end
                end
                ST_RX: begin
                    scl_low_ff <= (phase_ff == PH_LAST) || (phase_ff == 2'h0);
                    sda_low_ff <= 1'b0;
                end
                ST_STOP: begin
                    scl_low_ff <= (phase_ff == 2'h0);
                    sda_low_ff <= (phase_ff == 2'h0) || (phase_ff == PH_SCLHI);
                end
                default: begin
                    scl_low_ff <= 1'b0;
                    sda_low_ff <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Results and power-up load
    // ------------------------------------------------------------
    logic fin;
    assign fin = bit_end && (state_ff == ST_STOP);

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            done_ff   <= 1'b0;
            absent_ff <= 1'b0;
            data_ff   <= 8'h00;
        end else begin
            done_ff <= fin && boot_done_ff;
            if (fin) begin
                absent_ff <= nack_ff;
                data_ff   <= nack_ff ? 8'h00 : shift_ff;
            end
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_done_ff    <= 1'b0;
            job_ff          <= 3'h0;
            o_board_cfg     <= 8'h00;
            o_bank_a_size   <= 8'h00;
            o_mez_c_fitted  <= 1'b0;
            o_mez_c_size    <= 8'h00;
            o_mez_e_fitted  <= 1'b0;
            o_mez_e_size    <= 8'h00;
            o_spare_present <= 1'b0;
        end else if (fin && !boot_done_ff) begin
            job_ff <= job_ff + 3'h1;
            if (job_ff == BOOT_JOBS - 3'h1) begin
                boot_done_ff <= 1'b1;
            end
            case (job_ff)
                3'h0: o_board_cfg   <= nack_ff ? 8'h00 : shift_ff;
                3'h1: o_bank_a_size <= nack_ff ? 8'h00 : shift_ff;
                3'h2: begin
                    o_mez_c_fitted <= !nack_ff;
                    o_mez_c_size   <= nack_ff ? 8'h00 : shift_ff;
                end
                3'h3: begin
                    o_mez_e_fitted <= !nack_ff;
                    o_mez_e_size   <= nack_ff ? 8'h00 : shift_ff;
                end
                default: o_spare_present <= !nack_ff;
            endcase
        end
    end

    assign o_sda_o       = 1'b0;
    assign o_scl_o       = 1'b0;
    assign o_sda_oe      = sda_low_ff;
    assign o_scl_oe      = scl_low_ff;
    assign o_req_ready   = go && boot_done_ff;
    assign o_done        = done_ff;
    assign o_absent      = absent_ff;
    assign o_data        = data_ff;
    assign o_boot_done   = boot_done_ff;
    assign o_bank_b_size = o_bank_a_size;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n);

    chk_idle_release: assert property (
        (state_ff == ST_IDLE && $past(state_ff) == ST_IDLE)
        |-> !o_scl_oe && !o_sda_oe)
        else $error("Lines driven while idle");
    chk_start_cond: assert property (
        (state_ff == ST_START && tick && phase_ff == PH_SCLHI)
        |=> o_sda_oe && !o_scl_oe)
        else $error("Start condition malformed");
    chk_boot_gate: assert property (
        o_req_ready |-> boot_done_ff)
        else $error("Request taken before power-up load");
    chk_addr_shift: assert property (
        (state_ff == ST_START && bit_end && stage_ff == STG_ADDR_W)
        |=> shift_ff == {cur_sw[7:1], 1'b0})
        else $error("Slave address not shifted");
    chk_read_flag: assert property (
        (state_ff == ST_START && bit_end && stage_ff == STG_ADDR_R)
        |=> shift_ff[0] && state_ff == ST_TX)
        else $error("Read address lacks read flag");
    chk_nack_stop: assert property (
        (state_ff == ST_TX && bit_end && bit_ff == BIT_ACK && nack_ff)
        |=> state_ff == ST_STOP)
        else $error("Missing acknowledge not ended cleanly");
    chk_done_pulse: assert property (
        o_done |=> !o_done)
        else $error("Done longer than one cycle");
    chk_bank_share: assert property (
        o_boot_done |-> o_bank_b_size == o_bank_a_size)
        else $error("Bank B size differs");
    chk_spd_load: assert property (
        (fin && !boot_done_ff && job_ff == 3'h1 && !nack_ff)
        |=> o_bank_a_size == $past(shift_ff))
        else $error("Presence byte not stored");
    chk_stop_idle: assert property (
        fin |=> state_ff == ST_IDLE && !o_sda_oe && !o_scl_oe)
        else $error("Stop did not release lines");
endmodule
`default_nettype wire

// ---- bench/bcr_eeprom_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Serial EEPROM and sensor slaves sharing the two-wire bus
// ------------------------------------------------------------
module bcr_eeprom_model (
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    input  wire logic [7:0] i_fitted,
    output logic            o_sda_oe,
    output logic [7:0]      o_last_addr,
    output logic [7:0]      o_last_word
);
    import bcr_pkg::*;
    logic       p_scl;
    logic       p_sda;
    logic       active;
    logic       rd;
    logic       ackb;
    logic [1:0] stage;
    logic [7:0] sh;
    logic [7:0] dat;
    int         bitn;

    // One slave per select slot, each answering its own address only
    function automatic logic hit(input logic [6:0] a);
        logic [7:0] tbl [8];
        logic       r;
        tbl = '{SW_ADDR_BOARD, SW_ADDR_USER, SW_ADDR_ADDON, SW_ADDR_TEMP,
                SW_ADDR_MEM_AB, SW_ADDR_MEZ_C, SW_ADDR_MEZ_E, SW_ADDR_SPARE};
        r = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (i_fitted[i] && tbl[i][7:1] == a) begin
                r = 1'b1;
            end
        end
        return r;
    endfunction

    initial begin
        o_sda_oe = 1'b0;
        o_last_addr = 8'h00;
        o_last_word = 8'h00;
        active = 1'b0;
        rd = 1'b0;
        ackb = 1'b1;
        stage = 2'h0;
        sh = 8'h00;
        dat = 8'h00;
        bitn = 0;
        p_scl = 1'b1;
        p_sda = 1'b1;
        forever begin
            #5;
            if (i_scl && p_sda && !i_sda) begin
                active = 1'b1;
                stage = 2'h0;
                bitn = 0;
                o_sda_oe = 1'b0;
            end else if (i_scl && !p_sda && i_sda) begin
                active = 1'b0;
                o_sda_oe = 1'b0;
            end else if (active && i_scl && !p_scl) begin
                if (bitn < 8) begin
                    sh = {sh[6:0], i_sda};
                end else begin
                    ackb = i_sda;
                end
                bitn++;
            end else if (active && !i_scl && p_scl) begin
                o_sda_oe = 1'b0;
                if (bitn == 8 && stage == 2'h0) begin
                    if (hit(sh[7:1])) begin
                        o_sda_oe = 1'b1;
                        o_last_addr = sh;
                        rd = sh[0];
                    end else begin
                        active = 1'b0;
                    end
                end else if (bitn == 8 && stage == 2'h1) begin
                    // Single byte word address into 256 locations
                    o_sda_oe = 1'b1;
                    o_last_word = sh;
                    dat = sh + {1'b0, o_last_addr[7:1]};
                end else if (bitn == 9) begin
                    bitn = 0;
                    if (stage == 2'h0) begin
                        stage = rd ? 2'h2 : 2'h1;
                    end else if (stage == 2'h1) begin
                        stage = 2'h3;
                    end else if (stage == 2'h2 && ackb) begin
                        active = 1'b0;
                    end else if (stage == 2'h2) begin
                        dat = dat + 8'h01;
                    end
                    if (active && stage == 2'h2) begin
                        o_sda_oe = !dat[7];
                    end
                end else if (stage == 2'h2 && bitn < 8) begin
                    o_sda_oe = !dat[7 - bitn];
                end
            end
            p_scl = i_scl;
            p_sda = i_sda;
        end
    end
endmodule
`default_nettype wire

// ---- bench/board_config_i2c_reader_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module board_config_i2c_reader_tb;
    import bcr_pkg::*;
    logic       i_clk;
    logic       i_rst_n;
    logic       i_req;
    logic [2:0] i_dev_sel;
    logic [7:0] i_word_addr;
    logic       o_sda_o, o_sda_oe, o_scl_o, o_scl_oe, o_req_ready, o_done;
    logic       o_absent, o_boot_done, o_mez_c_fitted, o_mez_e_fitted;
    logic       o_spare_present;
    logic [7:0] o_data, o_board_cfg, o_bank_a_size, o_bank_b_size;
    logic [7:0] o_mez_c_size, o_mez_e_size, m_last_addr, m_last_word;
    logic       m_sda_oe;
    logic       bus_scl;
    logic       bus_sda;
    int         errors;
    int         num_checks;

    // Open-drain wires with pull-ups
    assign bus_scl = ~o_scl_oe;
    assign bus_sda = ~(o_sda_oe | m_sda_oe);

    bcr_reader i_dut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sda(bus_sda),
        .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .o_scl_o(o_scl_o),
        .o_scl_oe(o_scl_oe), .i_req(i_req), .i_dev_sel(i_dev_sel),
        .i_word_addr(i_word_addr), .o_req_ready(o_req_ready),
        .o_done(o_done), .o_absent(o_absent), .o_data(o_data),
        .o_boot_done(o_boot_done), .o_board_cfg(o_board_cfg),
        .o_bank_a_size(o_bank_a_size), .o_bank_b_size(o_bank_b_size),
        .o_mez_c_fitted(o_mez_c_fitted), .o_mez_c_size(o_mez_c_size),
        .o_mez_e_fitted(o_mez_e_fitted), .o_mez_e_size(o_mez_e_size),
        .o_spare_present(o_spare_present)
    );

    // Mezzanine E and the spare slot are not fitted
    bcr_eeprom_model i_slaves (
        .i_scl(bus_scl), .i_sda(bus_sda), .i_fitted(8'h3F),
        .o_sda_oe(m_sda_oe), .o_last_addr(m_last_addr),
        .o_last_word(m_last_word)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [7:0] mdat(input logic [7:0] sw,
                                        input logic [7:0] word);
        return word + {1'b0, sw[7:1]};
    endfunction

    task automatic finish_test;
        $display("Checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic issue(input logic [2:0] sel, input logic [7:0] word,
                         input int limit);
        int n;
        @(posedge i_clk);
        i_dev_sel <= sel;
        i_word_addr <= word;
        i_req <= 1'b1;
        n = 0;
        do begin
            @(negedge i_clk);
            n++;
        end while (o_req_ready !== 1'b1 && n < limit);
        check("ready", o_req_ready, 1'b1);
        @(posedge i_clk);
        i_req <= 1'b0;
    endtask

    task automatic collect(input logic [7:0] sw, input logic [7:0] word,
                           input logic absent);
        int n;
        n = 0;
        do begin
            @(negedge i_clk);
            n++;
        end while (o_done !== 1'b1 && n < 50000);
        check("done", o_done, 1'b1);
        check("absent", o_absent, absent);
        check("data", o_data, absent ? 8'h00 : mdat(sw, word));
        if (!absent) begin
            check("slave addr", m_last_addr, sw | 8'h01);
            check("word addr", m_last_word, word);
        end
        @(negedge i_clk);
        check("done pulse", o_done, 1'b0);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    always @(negedge i_clk) begin
        if (i_rst_n && o_boot_done !== 1'b1) begin
            check("early ready", o_req_ready | o_done, 1'b0);
        end
    end

    task automatic test_boot;
        int n;
        fork
            issue(3'h1, 8'h3C, 60000);
            begin
                n = 0;
                do begin
                    @(negedge i_clk);
                    n++;
                end while (o_boot_done !== 1'b1 && n < 60000);
                check("boot", o_boot_done, 1'b1);
                check("board", o_board_cfg,
                      mdat(SW_ADDR_BOARD, BOARD_CFG_IDX));
                check("bank a", o_bank_a_size,
                      mdat(SW_ADDR_MEM_AB, SPD_DENSITY_IDX));
                check("bank b", o_bank_b_size,
                      mdat(SW_ADDR_MEM_AB, SPD_DENSITY_IDX));
                check("mez c fit", o_mez_c_fitted, 1'b1);
                check("mez c", o_mez_c_size,
                      mdat(SW_ADDR_MEZ_C, SPD_DENSITY_IDX));
                check("mez e fit", o_mez_e_fitted, 1'b0);
                check("mez e", o_mez_e_size, 8'h00);
                check("spare", o_spare_present, 1'b0);
            end
        join
        collect(SW_ADDR_USER, 8'h3C, 1'b0);
    endtask

    task automatic test_reads;
        logic [2:0] sels [4];
        logic [7:0] sws  [4];
        logic [7:0] words [4];
        sels = '{3'h2, 3'h3, 3'h7, 3'h6};
        sws = '{SW_ADDR_ADDON, SW_ADDR_TEMP, SW_ADDR_SPARE, SW_ADDR_MEZ_E};
        words = '{8'hFF, 8'h00, 8'h10, 8'h1F};
        for (int i = 0; i < 4; i++) begin
            issue(sels[i], words[i], 5000);
            collect(sws[i], words[i], i >= 2);
        end
    endtask

    task automatic test_master_only;
        check("sda out", o_sda_o, 1'b0);
        check("scl out", o_scl_o, 1'b0);
        check("scl idle", o_scl_oe, 1'b0);
    endtask

    // ------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    initial begin
        #900000;
        errors++;
        finish_test();
    end

    initial begin
        errors = 0;
        num_checks = 0;
        i_rst_n = 1'b0;
        i_req = 1'b0;
        i_dev_sel = 3'h0;
        i_word_addr = 8'h00;
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
        test_boot();
        test_reads();
        test_master_only();
        finish_test();
    end
endmodule
`default_nettype wire
